// ==== bench/dma0_far_side.sv ====
// Far-side model: external requester and serial holding flags
`timescale 1ns/1ps
`default_nettype none
module dma0_far_side (
    // Clock and bus activity
    input wire logic sys_clk,
    input wire logic write_cycle,
    // Bench commands
    input wire logic level_req,
    input wire logic edge_req,
    input wire logic [3:0] flags_on,
    // Request sources
    output logic xfer_request_in_n,
    output logic [1:0] tx_holding_empty,
    output logic [1:0] rx_holding_full
);
    logic pulse_q = 1'b0;
    always @(posedge sys_clk) pulse_q <= edge_req;
    // Two cycles low per edge command, so the engine sees one clean falling edge
    assign xfer_request_in_n = !(level_req || edge_req || pulse_q);
    // Flags drop during the write cycle, since the holding register changes then
    assign tx_holding_empty = flags_on[1:0] & {2{!write_cycle}};
    assign rx_holding_full = flags_on[3:2] & {2{!write_cycle}};
endmodule // dma0_far_side
`default_nettype wire

// ==== bench/tb_dma0_sequencer.sv ====
// Bench for the channel 0 transfer sequencer
`timescale 1ns/1ps
`default_nettype none
`include "dma0_consts.svh"
module tb_dma0_sequencer;
    import dma0_pkg::*;
    logic sys_clk = 1'b0, sys_rst = 1'b1, enable_wr = 1'b0, wdata = 1'b1, mask = 1'b0, load_wr = 1'b0;
    logic burst = 1'b0, sense = 1'b0, irq_en = 1'b0, ck1_dis = 1'b0, pre_t3 = 1'b1, slow = 1'b0;
    logic level_req = 1'b0, edge_req = 1'b0, req_n, wr_prev = 1'b0, stolen = 1'b0, ck0_en = 1'b1;
    logic [19:0] src = 20'h0, dst = 20'h0, sp, dp;
    logic [15:0] cnt = 16'h0, bc;
    addr_mode_t sm = 2'h0, dm = 2'h0;
    logic [3:0] flags_on = 4'h0;
    logic [1:0] txe, rxf;
    logic ce, irq, hold, rd, wr, tend_n, tend_oe, ck0_oe;
    int bad_count = 0, num_checks = 0, writes = 0, gaps = 0, tend_bad = 0;

    dma0_sequencer dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .enable_wr(enable_wr), .channel_enable_wdata(wdata),
        .enable_write_mask(mask), .load_wr(load_wr), .source_load(src), .dest_load(dst), .count_load(cnt),
        .source_mode(sm), .dest_mode(dm), .burst_select(burst), .request_sense_select(sense),
        .done_irq_enable(irq_en), .serial_clock1_disable(ck1_dis), .serial_clock0_out_en(ck0_en), .pre_t3(pre_t3),
        .xfer_request_in_n(req_n), .tx_holding_empty(txe), .rx_holding_full(rxf), .channel_enable(ce),
        .dma_irq(irq), .bus_hold(hold), .read_cycle(rd), .write_cycle(wr), .transfer_end_out_n(tend_n),
        .transfer_end_oe(tend_oe), .serial_clock_pin0_oe(ck0_oe), .source_pointer(sp), .dest_pointer(dp),
        .byte_count(bc));
    dma0_far_side far (.sys_clk(sys_clk), .write_cycle(wr), .level_req(level_req), .edge_req(edge_req),
        .flags_on(flags_on), .xfer_request_in_n(req_n), .tx_holding_empty(txe), .rx_holding_full(rxf));

    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    // Slow mode inserts a wait state into every bus state
    always @(negedge sys_clk) pre_t3 <= slow ? ~pre_t3 : 1'b1;
    // Bytes, processor cycles between bytes, and end strobe outside the final write
    always @(negedge sys_clk) begin
        if (wr && !wr_prev) writes++;
        if (writes > 0 && !hold) stolen = 1'b1;
        if (rd && stolen) begin
            gaps++;
            stolen = 1'b0;
        end
        if (tend_n !== !(wr && bc === 16'h0 && (sm == `MODE_IO || dm == `MODE_IO))) tend_bad++;
        wr_prev = wr;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cfg(input addr_mode_t s_m, d_m, input logic [19:0] s, d, input logic [15:0] n);
        @(negedge sys_clk);
        {sm, dm, src, dst, cnt} = {s_m, d_m, s, d, n};
        load_wr = 1'b1;
        @(negedge sys_clk);
        load_wr = 1'b0;
        {writes, gaps, tend_bad, stolen} = 0;
    endtask
    task automatic enable(input logic m);
        @(negedge sys_clk);
        mask = m;
        enable_wr = 1'b1;
        @(negedge sys_clk);
        enable_wr = 1'b0;
    endtask
    task automatic pulse;
        @(negedge sys_clk);
        edge_req = 1'b1;
        @(negedge sys_clk);
        edge_req = 1'b0;
    endtask
    task automatic finish(input string name, input int n);
        for (int i = 0; i < 300 && ce === 1'b1; i++) @(negedge sys_clk);
        repeat (2) @(negedge sys_clk);
        chk("channel_enable", 0, ce);
        chk("bytes", n, writes);
        chk("tend_errors", 0, tend_bad);
        chk("dma_irq", irq_en, irq);
        $display("Test %s done", name);
    endtask

    task automatic t_burst;
        burst = 1'b1;
        irq_en = 1'b1;
        cfg(`MODE_INC, `MODE_DEC, 20'h01000, 20'h02000, 16'h2);
        enable(1'b0);
        @(negedge sys_clk);
        chk("irq_running", 2'h2, {ce, irq});
        finish("burst", 3);
        chk("steals", 0, gaps);
        chk("pointers", 0, {sp ^ 20'h01003, dp ^ 20'h01FFD});
        chk("clock0_oe", 1, ck0_oe);
    endtask
    task automatic t_steal;
        burst = 1'b0;
        irq_en = 1'b0;
        ck0_en = 1'b0;
        cfg(`MODE_FIXED, `MODE_INC, 20'h03000, 20'h04000, 16'h1);
        enable(1'b1);
        repeat (3) @(negedge sys_clk);
        chk("masked_enable", 0, ce);
        enable(1'b0);
        finish("steal", 2);
        chk("steals", 1, gaps);
        chk("clock0_oe_off", 0, ck0_oe);
        ck0_en = 1'b1;
        chk("pointers", 0, {sp ^ 20'h03000, dp ^ 20'h04002});
    endtask
    task automatic t_io_level;
        {sense, ck1_dis, slow} = 3'b011;
        cfg(`MODE_INC, `MODE_IO, 20'h15000, 20'h00040, 16'h1);
        irq_en = 1'b1;
        enable(1'b0);
        repeat (20) @(negedge sys_clk);
        chk("idle_bytes", 0, writes);
        chk("pin_dirs", 1, {ck0_oe, tend_oe});
        level_req = 1'b1;
        finish("io_level", 2);
        {level_req, slow} = 2'b00;
    endtask
    task automatic t_io_edge;
        sense = 1'b1;
        cfg(`MODE_IO, `MODE_INC, 20'h00041, 20'h06000, 16'h1);
        enable(1'b0);
        pulse();
        for (int i = 0; i < 50 && writes < 1; i++) @(negedge sys_clk);
        repeat (20) @(negedge sys_clk);
        chk("held_bytes", 1, writes);
        pulse();
        finish("io_edge", 2);
    endtask
    task automatic t_serial;
        logic [3:0] sel;
        level_req = 1'b1;
        for (int k = 0; k < 4; k++) begin
            sel = 4'h1 << k;
            if (k < 2) cfg(`MODE_INC, `MODE_IO, 20'h07000, {2'h0, 2'(k + 1), 8'h0, 8'(6 + k)}, 16'h0);
            else cfg(`MODE_IO, `MODE_INC, {2'h0, 2'(k - 1), 8'h0, 8'(6 + k)}, 20'h08000, 16'h0);
            enable(1'b0);
            flags_on = ~sel;
            repeat (20) @(negedge sys_clk);
            chk("wrong_flag_bytes", 0, writes);
            flags_on = sel;
            finish("serial", 1);
            flags_on = 4'h0;
        end
        level_req = 1'b0;
    endtask

    task automatic summarize;
        $display("Checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge sys_clk);
        chk("reset_outputs", 32'h1, {ce, irq, hold, rd, wr, tend_oe, ck0_oe, bc, tend_n});
        sys_rst = 1'b0;
        @(negedge sys_clk);
        t_burst();
        t_steal();
        t_io_level();
        t_io_edge();
        t_serial();
        summarize();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        summarize();
    end
endmodule // tb_dma0_sequencer
`default_nettype wire

// ==== design/dma0_consts.svh ====
// Constants for the channel 0 transfer sequencer
`ifndef DMA0_CONSTS_SVH
`define DMA0_CONSTS_SVH
`define ADDR_W 20
`define COUNT_W 16
`define REQ_SEL_LO 16
`define REQ_SEL_HI 17
`define REQ_SEL_PIN 2'h0
`define REQ_SEL_CH0 2'h1
`define REQ_SEL_CH1 2'h2
`define MODE_INC 2'h0
`define MODE_DEC 2'h1
`define MODE_FIXED 2'h2
`define MODE_IO 2'h3
`endif

// ==== design/dma0_pkg.sv ====
// Types for the channel 0 transfer sequencer
package dma0_pkg;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_START = 6'h02,
        ST_READ = 6'h04,
        ST_WRITE = 6'h08,
        ST_CPU = 6'h10,
        ST_WAITREQ = 6'h20
    } seq_state_t;
    typedef logic [1:0] addr_mode_t;
endpackage

// ==== design/dma0_sequencer.sv ====
// Channel 0 transfer sequencer: memory, I/O and serial-unit pacing
// Notes on behaviour
// - Memory-to-memory transfers ignore the request pin and are self-timed; fixed-to-fixed pairs wait for a request instead.
// - Self-timed modes keep transferring up to the byte moved at count zero, one byte more than the loaded count.
// - Burst mode holds the bus until the transfer completes.
// - Cycle-steal alternates one processor machine cycle with one byte transfer.
// - First memory transfer begins one machine cycle after enable is set.
// - Burst-select one picks burst, zero picks cycle-steal.
// - I/O transfers are paced by the active-low request input.
// - In I/O modes only, end-of-transfer output goes low during the write of the final byte.
// - Level sense: run while low; if high, release after current byte.
// - Level sense samples the request in the state before T3.
// - Edge sense: a falling request edge starts transfers.
// - Edge sense: a new edge before write T3 continues, else release.
// - While processor owns bus, a falling edge restarts transfers.
// - Sense select zero is level, one is edge; resets to zero.
// - Memory-to-I/O mode forces the shared request pin to input; here only while the channel is enabled.
// - Shared pin becomes end-of-transfer output when serial clock 1 disabled.
// - Serial transfers use transmit-empty or receive-full flags, not the pin.
// - Source bits 17:16 pick pin, receive-full 0, receive-full 1, reserved.
// - Dest bits 17:16 pick pin, transmit-empty 0, transmit-empty 1, reserved.
// - At count zero clear enable; enable clear and irq enable raise irq.
`timescale 1ns/1ps
`default_nettype none
`include "dma0_consts.svh"

module dma0_sequencer #(
    parameter int ADDR_W = `ADDR_W,
    parameter int COUNT_W = `COUNT_W
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Software control
    input wire logic enable_wr,
    input wire logic channel_enable_wdata,
    input wire logic enable_write_mask,
    input wire logic load_wr,
    input wire logic [ADDR_W-1:0] source_load,
    input wire logic [ADDR_W-1:0] dest_load,
    input wire logic [COUNT_W-1:0] count_load,
    input wire dma0_pkg::addr_mode_t source_mode,
    input wire dma0_pkg::addr_mode_t dest_mode,
    input wire logic burst_select,
    input wire logic request_sense_select,
    input wire logic done_irq_enable,
    input wire logic serial_clock1_disable,
    input wire logic serial_clock0_out_en,
    // Bus cycle progress: high when T2 or wait state ends next edge into T3
    input wire logic pre_t3,
    // Request sources
    input wire logic xfer_request_in_n,
    input wire logic [1:0] tx_holding_empty,
    input wire logic [1:0] rx_holding_full,
    // Status and bus use
    output logic channel_enable,
    output logic dma_irq,
    output logic bus_hold,
    output logic read_cycle,
    output logic write_cycle,
    output logic transfer_end_out_n,
    output logic transfer_end_oe,
    output logic serial_clock_pin0_oe,
    output logic [ADDR_W-1:0] source_pointer,
    output logic [ADDR_W-1:0] dest_pointer,
    output logic [COUNT_W-1:0] byte_count
);
    import dma0_pkg::*;

    seq_state_t state_q;
    seq_state_t state_d;
    logic req_prev_q;
    logic edge_seen_q;
    logic io_mode;
    logic mem_mode;
    logic serial_req;
    logic [1:0] req_sel;
    logic ext_req;
    logic req_now;
    logic last_byte;
    logic fall_edge;
    logic edge_take;

    function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a, input addr_mode_t m);
        case (m)
            `MODE_INC: step_addr = a + ADDR_W'(1);
            `MODE_DEC: step_addr = a - ADDR_W'(1);
            default: step_addr = a;
        endcase
    endfunction

    // Request source field, same bits in either pointer
    function automatic logic [1:0] req_field(input logic [ADDR_W-1:0] a);
        req_field = a[`REQ_SEL_HI:`REQ_SEL_LO];
    endfunction

    assign io_mode = (source_mode == `MODE_IO) || (dest_mode == `MODE_IO);
    assign mem_mode = !io_mode && !(source_mode == `MODE_FIXED && dest_mode == `MODE_FIXED);
    // The I/O side's pointer carries the field; a memory address above 64K
    // on the other side must not steal the request from the pin
    always_comb begin
        if (dest_mode == `MODE_IO) begin
            req_sel = req_field(dest_pointer);
        end else begin
            req_sel = req_field(source_pointer);
        end
    end
    always_comb begin
        serial_req = 1'b0;
        case (req_sel)
            `REQ_SEL_CH0: serial_req = (dest_mode == `MODE_IO) ?
                                      tx_holding_empty[0] : rx_holding_full[0];
            `REQ_SEL_CH1: serial_req = (dest_mode == `MODE_IO) ?
                                      tx_holding_empty[1] : rx_holding_full[1];
            default: serial_req = 1'b0;
        endcase
    end
    assign ext_req = (req_sel == `REQ_SEL_PIN);
    assign fall_edge = req_prev_q && !xfer_request_in_n;
    // Request seen at pre-T3 edge
    assign req_now = !ext_req ? serial_req :
                     (request_sense_select ? (edge_seen_q || fall_edge) : !xfer_request_in_n);
    assign last_byte = (byte_count == '0);
    assign edge_take = pre_t3 && (state_q == ST_WRITE || state_q == ST_WAITREQ);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            req_prev_q <= 1'b1;
        end else begin
            req_prev_q <= xfer_request_in_n;
        end
    end

    // Edge latch; an edge used at the same pre-T3 edge is not kept,
    // else it would fetch a second byte. Edges while off are dropped.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            edge_seen_q <= 1'b0;
        end else if (edge_take) begin
            edge_seen_q <= 1'b0;
        end else if (fall_edge && channel_enable) begin
            edge_seen_q <= 1'b1;
        end else if (!channel_enable) begin
            edge_seen_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            channel_enable <= 1'b0;
        end else if (state_q == ST_WRITE && pre_t3 && last_byte) begin
            channel_enable <= 1'b0;
        end else if (enable_wr && !enable_write_mask) begin
            channel_enable <= channel_enable_wdata;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dma_irq <= 1'b0;
        end else begin
            dma_irq <= !channel_enable && done_irq_enable;
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: if (channel_enable) state_d = mem_mode ? ST_START : ST_WAITREQ;
            ST_START: if (pre_t3) state_d = ST_READ;
            ST_WAITREQ: if (pre_t3 && req_now) state_d = ST_READ;
            ST_READ: if (pre_t3) state_d = ST_WRITE;
            ST_WRITE: begin
                if (pre_t3) begin
                    if (last_byte) state_d = ST_IDLE;
                    else if (mem_mode) state_d = burst_select ? ST_READ : ST_CPU;
                    else state_d = req_now ? ST_READ : ST_WAITREQ;
                end
            end
            ST_CPU: if (pre_t3) state_d = ST_READ;
            default: state_d = ST_IDLE;
        endcase
        if (!channel_enable && state_q != ST_WRITE) state_d = ST_IDLE;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_hold <= 1'b0;
            read_cycle <= 1'b0;
            write_cycle <= 1'b0;
        end else begin
            bus_hold <= (state_d == ST_READ) || (state_d == ST_WRITE);
            read_cycle <= (state_d == ST_READ);
            write_cycle <= (state_d == ST_WRITE);
        end
    end

    // Pointers and count load only while the channel is off
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            source_pointer <= '0;
            dest_pointer <= '0;
            byte_count <= '0;
        end else if (load_wr && !channel_enable) begin
            source_pointer <= source_load;
            dest_pointer <= dest_load;
            byte_count <= count_load;
        end else if (state_q == ST_WRITE && pre_t3) begin
            source_pointer <= step_addr(source_pointer, source_mode);
            dest_pointer <= step_addr(dest_pointer, dest_mode);
            if (!last_byte) byte_count <= byte_count - COUNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            transfer_end_out_n <= 1'b1;
            transfer_end_oe <= 1'b0;
            serial_clock_pin0_oe <= 1'b0;
        end else begin
            transfer_end_out_n <= !(state_d == ST_WRITE && last_byte && io_mode);
            transfer_end_oe <= serial_clock1_disable;
            serial_clock_pin0_oe <= serial_clock0_out_en && !(channel_enable && io_mode);
        end
    end

    property p_irq_level;
        @(posedge sys_clk) disable iff (sys_rst) (!channel_enable && done_irq_enable) |=> dma_irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq missing");
    property p_end_clears;
        @(posedge sys_clk) disable iff (sys_rst) (state_q == ST_WRITE && pre_t3 && last_byte) |=> !channel_enable;
    endproperty
    a_end_clears: assert property (p_end_clears) else $error("enable not cleared");
    property p_burst;
        @(posedge sys_clk) disable iff (sys_rst)
            (state_q == ST_WRITE && pre_t3 && !last_byte && mem_mode && burst_select) |=> state_q == ST_READ;
    endproperty
    a_burst: assert property (p_burst) else $error("burst released bus");
    property p_steal;
        @(posedge sys_clk) disable iff (sys_rst)
            (state_q == ST_WRITE && pre_t3 && !last_byte && mem_mode && !burst_select) |=> state_q == ST_CPU;
    endproperty
    a_steal: assert property (p_steal) else $error("no cpu cycle");
    property p_tend;
        @(posedge sys_clk) disable iff (sys_rst) !transfer_end_out_n |-> write_cycle && last_byte;
    endproperty
    a_tend: assert property (p_tend) else $error("tend misplaced");
    property p_level_release;
        @(posedge sys_clk) disable iff (sys_rst)
            (state_q == ST_WRITE && pre_t3 && !last_byte && io_mode && !req_now) |=> state_q == ST_WAITREQ;
    endproperty
    a_level_release: assert property (p_level_release) else $error("bus kept");
    property p_pin_input;
        @(posedge sys_clk) disable iff (sys_rst) (channel_enable && io_mode) |=> !serial_clock_pin0_oe;
    endproperty
    a_pin_input: assert property (p_pin_input) else $error("request pin driven");
    property p_tend_oe;
        @(posedge sys_clk) disable iff (sys_rst) serial_clock1_disable |=> transfer_end_oe;
    endproperty
    a_tend_oe: assert property (p_tend_oe) else $error("tend pin not output");
    property p_start_delay;
        @(posedge sys_clk) disable iff (sys_rst) (channel_enable && state_q == ST_IDLE && mem_mode) |=> state_q == ST_START;
    endproperty
    a_start_delay: assert property (p_start_delay) else $error("memory start not delayed");
    property p_level_start;
        @(posedge sys_clk) disable iff (sys_rst)
            (state_q == ST_WAITREQ && pre_t3 && channel_enable && ext_req && !request_sense_select
             && !xfer_request_in_n) |=> state_q == ST_READ;
    endproperty
    a_level_start: assert property (p_level_start) else $error("level request ignored");
    property p_edge_restart;
        @(posedge sys_clk) disable iff (sys_rst)
            (state_q == ST_WAITREQ && pre_t3 && channel_enable && ext_req && request_sense_select
             && fall_edge) |=> state_q == ST_READ && !edge_seen_q;
    endproperty
    a_edge_restart: assert property (p_edge_restart) else $error("edge start wrong");
    property p_edge_single;
        @(posedge sys_clk) disable iff (sys_rst)
            (state_q == ST_WRITE && pre_t3 && !last_byte && io_mode && ext_req && request_sense_select
             && !edge_seen_q && !fall_edge) |=> state_q == ST_WAITREQ;
    endproperty
    a_edge_single: assert property (p_edge_single) else $error("byte without new edge");
    property p_count_step;
        @(posedge sys_clk) disable iff (sys_rst)
            (state_q == ST_WRITE && pre_t3 && channel_enable && !last_byte)
            |=> byte_count == $past(byte_count) - COUNT_W'(1);
    endproperty
    a_count_step: assert property (p_count_step) else $error("count not stepped");
    property p_serial_pin;
        @(posedge sys_clk) disable iff (sys_rst)
            (state_q == ST_WAITREQ && pre_t3 && channel_enable && !ext_req && !serial_req)
            |=> state_q == ST_WAITREQ;
    endproperty
    a_serial_pin: assert property (p_serial_pin) else $error("serial transfer without flag");
    c_burst: cover property (@(posedge sys_clk) state_q == ST_WRITE ##1 state_q == ST_READ);
    c_steal: cover property (@(posedge sys_clk) state_q == ST_CPU);
    c_end: cover property (@(posedge sys_clk) !transfer_end_out_n);
    c_wait: cover property (@(posedge sys_clk) state_q == ST_WAITREQ ##1 state_q == ST_READ);
endmodule // dma0_sequencer
`default_nettype wire
